// ===== sim/vfd_font_ram_and_shutdown_test.sv
`timescale 1ns/1ps
module vfd_font_ram_and_shutdown_test;
	import vfdfs_pkg::*;
	logic       mclk, sys_rst, ce, displayTest, pumpIsClock;
	logic       filAIsDriver, filBIsDriver, spiCsN, spiSclk, spiDin;
	logic       spiDout, tubeDriverBlank, scanOscillatorRun;
	logic       muxPeriodTick, pumpOut, filamentDriveA, filamentDriveB;
	logic       cfgLock, cfgBlinkFast, cfgTwoRow;
	int         errors, nTests, ptr, k, i;
	int         mem [48];
	bit         done;
	logic [7:0] r, a;
	logic [5:0] seen;
	logic [7:0] pwr [24] = '{8'h7e, 8'h30, 8'h6d, 8'h79, 8'h33, 8'h5b,
		8'h5f, 8'h70, 8'h7f, 8'h7b, 8'h77, 8'h1f, 8'h4e, 8'h3d, 8'h4f,
		8'h47, 8'h0d, 8'h15, 8'h76, 8'h1d, 8'h05, 8'h4f, 8'h1c, 8'h3b};

	vfdfs_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
		.spiCsN(spiCsN), .spiSclk(spiSclk), .spiDin(spiDin),
		.spiDout(spiDout), .spiDoutEn(), .displayTest(displayTest),
		.pumpIsClock(pumpIsClock), .filAIsDriver(filAIsDriver),
		.filBIsDriver(filBIsDriver), .tubeDriverBlank(tubeDriverBlank),
		.scanOscillatorRun(scanOscillatorRun),
		.muxPeriodTick(muxPeriodTick), .pumpOut(pumpOut),
		.filamentDriveA(filamentDriveA), .filamentDriveB(filamentDriveB),
		.cfgLock(cfgLock), .cfgBlinkFast(cfgBlinkFast),
		.cfgTwoRow(cfgTwoRow), .cfgClearPulse(), .cfgBlinkResetPulse());
	vfdfs_host i_host (.spiCsN(spiCsN), .spiSclk(spiSclk),
		.spiDin(spiDin), .spiDout(spiDout));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ********
	// helpers
	// ********
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nTests++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks=%0d errors=%0d", nTests, errors);
		if (errors == 0 && nTests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// one frame on the glyph port, mirrored by the reference model
	task automatic acc(input logic [7:0] cmd, input logic [7:0] d);
		logic [7:0] g;
		int         e;
		step(1);
		i_host.xfer(cmd, d, g);
		e = -1;
		if (cmd == 8'h85) begin
			if (!done) e = mem[ptr-128];
			d = 8'h00;
		end
		if (d[7]) begin
			ptr = (d >= 8'hb0) ? 8'h80 : d;
			done = 0;
		end else if (!done) begin
			if (cmd == 8'h05) mem[ptr-128] = d;
			if (ptr == 8'haf) done = 1;
			else ptr++;
		end
		if (e >= 0) chk(g, e[7:0]);
	endtask

	task automatic pins(input logic [7:0] exp);
		chk({3'h0, tubeDriverBlank, scanOscillatorRun, pumpOut,
			filamentDriveA, filamentDriveB}, exp);
	endtask

	initial begin
		#1_000_000;
		errors++;
		test_done();
	end

	// ********
	// main sequence
	// ********
	initial begin
		{errors, nTests, ptr, done} = {32'd0, 32'd0, 32'd128, 1'b0};
		for (i = 0; i < 24; i++) begin
			mem[2*i] = pwr[i];
			mem[2*i+1] = 0;
		end
		{ce, sys_rst, displayTest} = 3'b110;
		{pumpIsClock, filAIsDriver, filBIsDriver} = 3'b111;
		void'($urandom(32'h27a2));
		step(3);
		sys_rst = 1'b0;
		step(4);
		for (k = 0; k < 12000 && scanOscillatorRun !== 1'b0; k++) step(1);
		pins(8'h10);
		acc(8'h05, 8'h80);
		for (i = 0; i < 48; i++) acc(8'h85, 8'h00);
		acc(8'h05, 8'hb0 + 8'($urandom_range(79)));
		acc(8'h85, 8'h00);
		acc(8'h85, 8'h00);
		for (k = 0; k < 4; k++) begin
			a = 8'h80 + 8'($urandom_range(45));
			acc(8'h05, a);
			acc(8'h05, 8'($urandom_range(127)));
			acc(8'h05, 8'($urandom_range(127)));
			acc(8'h05, a);
			acc(8'h85, 8'h00);
			acc(8'h85, 8'h00);
		end
		acc(8'h05, 8'hae);
		acc(8'h05, 8'h2a);
		acc(8'h05, 8'h55);
		acc(8'h05, 8'h7f);
		acc(8'h85, 8'h00);
		acc(8'h05, 8'hae);
		acc(8'h85, 8'h00);
		acc(8'h85, 8'h00);
		pins(8'h10);
		// leave shutdown: one blanked flush period
		i_host.xfer(8'h04, 8'h01, r);
		for (k = 0; k < 200 && scanOscillatorRun !== 1'b1; k++) step(1);
		step(9000);
		chk({7'h0, tubeDriverBlank}, 8'h01);
		for (k = 0; k < 2000 && tubeDriverBlank !== 1'b0; k++) step(1);
		chk({6'h0, tubeDriverBlank, scanOscillatorRun}, 8'h01);
		seen = 6'h00;
		for (k = 0; k < 140; k++) begin
			seen |= {pumpOut, filamentDriveA, filamentDriveB,
				~pumpOut, ~filamentDriveA, ~filamentDriveB};
			step(1);
		end
		chk({2'h0, seen}, 8'h3f);
		// mid-period entry must wait for the boundary
		i_host.xfer(8'h04, 8'h0c, r);
		step(1);
		chk({7'h0, scanOscillatorRun}, 8'h01);
		for (k = 0; k < 10100 && muxPeriodTick !== 1'b1; k++) step(1);
		step(3);
		pins(8'h10);
		chk({6'h0, cfgBlinkFast, cfgTwoRow}, 8'h03);
		i_host.xfer(8'h84, 8'h00, r);
		chk(r, 8'h0c);
		acc(8'h05, 8'hae);
		acc(8'h85, 8'h00);
		displayTest = 1'b1;
		for (k = 0; k < 21000 && tubeDriverBlank !== 1'b0; k++) step(1);
		chk({6'h0, tubeDriverBlank, scanOscillatorRun}, 8'h01);
		displayTest = 1'b0;
		step(20);
		test_done();
	end
endmodule

// ===== sim/vfdfs_host.sv
`timescale 1ns/1ps
module vfdfs_host (
	// serial port
	output logic      spiCsN,
	output logic      spiSclk,
	output logic      spiDin,
	input  wire logic spiDout
);
	// ********
	// host frame
	// ********
	// sclk stands low between frames
	initial begin
		spiCsN = 1'b1;
		spiSclk = 1'b0;
		spiDin = 1'b0;
	end

	task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
		output logic [7:0] rd);
		logic [15:0] w;
		w = {cmd, dat};
		rd = 8'h00;
		spiCsN = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spiDin = w[i];
			#62.5;
			if (i < 8) rd = {rd[6:0], spiDout};
			spiSclk = 1'b1;
			#62.5;
			spiSclk = 1'b0;
		end
		#62.5;
		spiCsN = 1'b1;
		// released line must not look like a held value
		spiDin = ~spiDin;
		#125;
	endtask
endmodule

// ===== verilog/vfdfs_glyph_ram.sv
`timescale 1ns/1ps
module vfdfs_glyph_ram
	import vfdfs_pkg::*;
#(
	parameter int DEPTH = GLYPH_ENTRIES,
	parameter int WIDTH = GLYPH_WIDTH,
	parameter int AW    = GLYPH_ADDR_W
) (
	// clock
	input  wire logic             mclk,
	input  wire logic             ce,
	// access
	input  wire logic             wrEn,
	input  wire logic [AW-1:0]    addr,
	input  wire logic [WIDTH-1:0] wrData,
	output logic      [WIDTH-1:0] rdData
);
	// ******************************************************************
	// power-up glyphs
	// ******************************************************************
	// byte 0 of slots 0..23 hold seven-segment patterns, byte 1 holds zero
	function automatic logic [WIDTH-1:0] preset(input int idx);
		logic [6:0] pat [24];
		pat = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
			7'h7f, 7'h7b, 7'h77, 7'h1f, 7'h4e, 7'h3d, 7'h4f, 7'h47,
			7'h0d, 7'h15, 7'h76, 7'h1d, 7'h05, 7'h4f, 7'h1c, 7'h3b};
		if (idx[0] || idx / 2 >= 24) begin
			return '0;
		end
		return WIDTH'(pat[idx / 2]);
	endfunction

	logic [WIDTH-1:0] mem [DEPTH];

	// ram carries no reset: contents survive shutdown and only load at start
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = preset(i);
		end
	end

	always_ff @(posedge mclk) begin
		if (ce) begin
			if (wrEn) begin
				mem[addr] <= wrData;
			end
			rdData <= mem[addr];
		end
	end
endmodule

// ===== verilog/vfdfs_pkg.sv
package vfdfs_pkg;
	// ******************************************************************
	// register access
	// ******************************************************************
	localparam logic [7:0] GLYPH_WR_ADDR   = 8'h05;
	localparam logic [7:0] GLYPH_RD_ADDR   = 8'h85;
	localparam logic [7:0] CONFIG_WR_ADDR  = 8'h04;
	localparam logic [7:0] CONFIG_RD_ADDR  = 8'h84;
	localparam logic [7:0] CONFIG_RESET    = 8'h00;
	localparam int         CFG_SHDN_BIT    = 0;
	localparam int         CFG_LOCK_BIT    = 1;
	localparam int         CFG_BLINK_BIT   = 2;
	localparam int         CFG_CLEAR_BIT   = 5;
	localparam int         CFG_BRESET_BIT  = 4;
	localparam int         CFG_ROWS_BIT    = 3;
	localparam int         SPI_BITS        = 16;

	// ******************************************************************
	// glyph pointer
	// ******************************************************************
	localparam logic [7:0] PTR_FIRST       = 8'h80;
	localparam logic [7:0] PTR_LAST        = 8'haf;
	localparam logic [7:0] PTR_RESET       = 8'h80;
	localparam int         GLYPH_ENTRIES   = 48;
	localparam int         GLYPH_WIDTH     = 7;
	localparam int         GLYPH_ADDR_W    = 6;

	// ******************************************************************
	// multiplex timing
	// ******************************************************************
	localparam int         CLK_MHZ         = 100;
	localparam int         MUX_PERIOD_US   = 100;
	localparam int         MUX_CYCLES      = MUX_PERIOD_US * CLK_MHZ;
	localparam int         MUX_CNT_W       = 14;
	localparam int         PUMP_HALF       = 16;
	localparam int         FIL_HALF        = 64;

	typedef enum logic [1:0] {
		VFDFS_RUN,
		VFDFS_STOPPING,
		VFDFS_HALTED,
		VFDFS_FLUSH
	} vfdfs_pwr_t;
endpackage

// ===== verilog/vfdfs_top.sv
`timescale 1ns/1ps
// Functional notes
// - read at 0x85 returns glyph at pointer, bit 7 zero, then advance
// - write with bit 7 clear stores low 7 bits, then advance
// - write with bit 7 set loads the pointer, glyphs untouched
// - pointer 0x80..0xAE auto-increments after each data access
// - after an access at 0xAF further data accesses are ignored
// - pointer load of 0xB0..0xFF sets pointer to 0x80
// - slot n uses entries 0x80+2n and the next one
// - power-up glyph patterns in byte 0, zero in byte 1
// - config bit D0 one means run, zero means shutdown
// - register writes accepted during shutdown
// - display test mode overrides shutdown
// - finish current mux period, halt oscillator, blank throughout
// - registers retained unchanged during shutdown
// - pump square wave held low in shutdown, resumes after
// - filament outputs held low in shutdown when filAIsDriver/filBIsDriver set, else hold their level; restored after
// - first mux cycle after exit stays blanked
// - shutdown bit lives in config register with other controls
// - pointer writable but never readable
module vfdfs_top
	import vfdfs_pkg::*;
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic ce,
	// serial host port
	input  wire logic spiCsN,
	input  wire logic spiSclk,
	input  wire logic spiDin,
	output logic      spiDout,
	output logic      spiDoutEn,
	// device controls
	input  wire logic displayTest,
	input  wire logic pumpIsClock,
	input  wire logic filAIsDriver,
	input  wire logic filBIsDriver,
	// tube and supply outputs
	output logic      tubeDriverBlank,
	output logic      scanOscillatorRun,
	output logic      muxPeriodTick,
	output logic      pumpOut,
	output logic      filamentDriveA,
	output logic      filamentDriveB,
	// configuration fields toward the scan engine
	output logic      cfgLock,
	output logic      cfgBlinkFast,
	output logic      cfgTwoRow,
	output logic      cfgClearPulse,
	output logic      cfgBlinkResetPulse
);
	// ******************************************************************
	// state
	// ******************************************************************
	typedef struct packed {
		logic [2:0]           csSync;
		logic [2:0]           sclkSync;
		logic [2:0]           dinSync;
		logic                 csLvl;
		logic                 sclkLvl;
		logic [4:0]           bitCnt;
		logic [15:0]          shiftIn;
		logic [7:0]           shiftOut;
		logic                 dout;
		logic                 doutEn;
		logic [7:0]           ptr;
		logic                 ptrDone;
		logic [7:0]           cfgReg;
		logic                 clearPulse;
		logic                 bresetPulse;
		logic                 rdPending;
		vfdfs_pwr_t           pwr;
		logic [MUX_CNT_W-1:0] muxCnt;
		logic                 tick;
		logic                 blank;
		logic [4:0]           pumpCnt;
		logic                 pump;
		logic [6:0]           filCnt;
		logic                 filA;
		logic                 filB;
	} vfdfs_state_t;

	vfdfs_state_t cur_ff;
	vfdfs_state_t nxt_cur;

	localparam logic [MUX_CNT_W-1:0] MUX_LAST = MUX_CNT_W'(MUX_CYCLES - 1);

	logic                   ramWr;
	logic [GLYPH_WIDTH-1:0] ramRd;
	logic [GLYPH_WIDTH-1:0] ramWrData;
	logic [7:0]             ptrOffset;

	// entry index is the pointer minus 0x80, so slot n byte b sits at 2n+b
	assign ptrOffset = cur_ff.ptr - PTR_FIRST;

	vfdfs_glyph_ram u_ram (
		.mclk   (mclk),
		.ce     (ce),
		.wrEn   (ramWr),
		.addr   (ptrOffset[GLYPH_ADDR_W-1:0]),
		.wrData (ramWrData),
		.rdData (ramRd)
	);

	// ******************************************************************
	// next state
	// ******************************************************************
	always_comb begin
		logic       sclkRise;
		logic       sclkFall;
		logic       csIdle;
		logic [7:0] cmd;
		logic [7:0] data;
		logic       wantRun;
		logic       endPeriod;
		sclkRise = 1'b0;
		sclkFall = 1'b0;
		csIdle   = 1'b0;
		cmd      = '0;
		data     = '0;
		wantRun  = 1'b0;
		endPeriod = 1'b0;
		nxt_cur  = cur_ff;
		ramWr    = 1'b0;
		ramWrData = '0;
		nxt_cur.clearPulse  = 1'b0;
		nxt_cur.bresetPulse = 1'b0;
		nxt_cur.tick        = 1'b0;

		// pins pass three flops; a level counts once stages two and three agree
		nxt_cur.csSync   = {cur_ff.csSync[1:0], spiCsN};
		nxt_cur.sclkSync = {cur_ff.sclkSync[1:0], spiSclk};
		nxt_cur.dinSync  = {cur_ff.dinSync[1:0], spiDin};
		if (cur_ff.csSync[2] == cur_ff.csSync[1]) begin
			nxt_cur.csLvl = cur_ff.csSync[2];
		end
		if (cur_ff.sclkSync[2] == cur_ff.sclkSync[1]) begin
			nxt_cur.sclkLvl = cur_ff.sclkSync[2];
		end
		sclkRise = nxt_cur.sclkLvl && !cur_ff.sclkLvl;
		sclkFall = !nxt_cur.sclkLvl && cur_ff.sclkLvl;
		csIdle   = cur_ff.csLvl;

		// serial frame: 8-bit command then 8-bit data, msb first
		if (csIdle) begin
			nxt_cur.bitCnt = '0;
			nxt_cur.doutEn = 1'b0;
			nxt_cur.dout   = 1'b0;
		end else begin
			nxt_cur.doutEn = 1'b1;
			if (sclkRise && cur_ff.bitCnt < 5'(SPI_BITS)) begin
				nxt_cur.shiftIn = {cur_ff.shiftIn[14:0], cur_ff.dinSync[2]};
				nxt_cur.bitCnt  = cur_ff.bitCnt + 5'd1;
			end
			if (sclkFall && cur_ff.bitCnt >= 5'd8) begin
				nxt_cur.dout     = cur_ff.shiftOut[7];
				nxt_cur.shiftOut = {cur_ff.shiftOut[6:0], 1'b0};
			end
		end

		// a read's data comes from ram one cycle after the command byte
		if (cur_ff.rdPending) begin
			nxt_cur.rdPending = 1'b0;
			nxt_cur.shiftOut  = {1'b0, ramRd};
		end

		if (!csIdle && sclkRise && cur_ff.bitCnt == 5'd7) begin
			cmd = {cur_ff.shiftIn[6:0], cur_ff.dinSync[2]};
			nxt_cur.shiftOut = '0;
			if (cmd == GLYPH_RD_ADDR && !cur_ff.ptrDone) begin
				nxt_cur.rdPending = 1'b1;
				if (cur_ff.ptr == PTR_LAST) begin
					nxt_cur.ptrDone = 1'b1;
				end else begin
					nxt_cur.ptr = cur_ff.ptr + 8'd1;
				end
			end else if (cmd == CONFIG_RD_ADDR) begin
				nxt_cur.shiftOut = cur_ff.cfgReg;
			end
			// pointer itself has no read command
		end

		// writes land at the end of the frame, shutdown or not
		if (!csIdle && sclkRise && cur_ff.bitCnt == 5'(SPI_BITS - 1)) begin
			cmd  = cur_ff.shiftIn[14:7];
			data = {cur_ff.shiftIn[6:0], cur_ff.dinSync[2]};
			if (cmd == GLYPH_WR_ADDR) begin
				if (data[7]) begin
					nxt_cur.ptrDone = 1'b0;
					if (data > PTR_LAST) begin
						nxt_cur.ptr = PTR_RESET;
					end else begin
						nxt_cur.ptr = data;
					end
				end else if (!cur_ff.ptrDone) begin
					ramWr     = 1'b1;
					ramWrData = data[6:0];
					if (cur_ff.ptr == PTR_LAST) begin
						nxt_cur.ptrDone = 1'b1;
					end else begin
						nxt_cur.ptr = cur_ff.ptr + 8'd1;
					end
				end
			end else if (cmd == CONFIG_WR_ADDR) begin
				nxt_cur.cfgReg = data;
				nxt_cur.cfgReg[CFG_CLEAR_BIT]  = 1'b0;
				nxt_cur.cfgReg[CFG_BRESET_BIT] = 1'b0;
				nxt_cur.clearPulse  = data[CFG_CLEAR_BIT];
				nxt_cur.bresetPulse = data[CFG_BRESET_BIT];
			end
		end

		// ******************************************************************
		// power sequencing
		// ******************************************************************
		wantRun = cur_ff.cfgReg[CFG_SHDN_BIT] || displayTest;
		endPeriod = cur_ff.muxCnt == MUX_LAST;
		if (cur_ff.pwr != VFDFS_HALTED) begin
			nxt_cur.muxCnt = endPeriod ? '0 : cur_ff.muxCnt + 1'b1;
			nxt_cur.tick   = endPeriod;
		end
		unique case (cur_ff.pwr)
			VFDFS_RUN: begin
				if (!wantRun) begin
					nxt_cur.pwr = VFDFS_STOPPING;
				end
			end
			VFDFS_STOPPING: begin
				// the period in progress runs out before the halt
				if (endPeriod) begin
					nxt_cur.pwr = wantRun ? VFDFS_RUN : VFDFS_HALTED;
				end
			end
			VFDFS_HALTED: begin
				nxt_cur.muxCnt = '0;
				if (wantRun) begin
					nxt_cur.pwr = VFDFS_FLUSH;
				end
			end
			VFDFS_FLUSH: begin
				// stale shift data is flushed while still blanked
				if (endPeriod) begin
					nxt_cur.pwr = VFDFS_RUN;
				end
			end
		endcase
		nxt_cur.blank = nxt_cur.pwr == VFDFS_HALTED
			|| nxt_cur.pwr == VFDFS_FLUSH;

		// pump and filament counters keep phase frozen in shutdown
		if (nxt_cur.pwr == VFDFS_HALTED) begin
			nxt_cur.pump = 1'b0;
			nxt_cur.filA = !filAIsDriver && cur_ff.filA;
			nxt_cur.filB = !filBIsDriver && cur_ff.filB;
		end else begin
			nxt_cur.pumpCnt = cur_ff.pumpCnt + 5'd1;
			if (cur_ff.pumpCnt == 5'(PUMP_HALF - 1)) begin
				nxt_cur.pumpCnt = '0;
				nxt_cur.pump    = pumpIsClock && !cur_ff.pump;
			end
			nxt_cur.filCnt = cur_ff.filCnt + 7'd1;
			if (cur_ff.filCnt == 7'(FIL_HALF - 1)) begin
				nxt_cur.filCnt = '0;
				nxt_cur.filA   = !cur_ff.filA;
				nxt_cur.filB   = cur_ff.filA;
			end
		end
	end

	// ******************************************************************
	// registers
	// ******************************************************************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cur_ff        <= '0;
			cur_ff.csSync <= 3'b111;
			cur_ff.csLvl  <= 1'b1;
			cur_ff.ptr    <= PTR_RESET;
			cur_ff.cfgReg <= CONFIG_RESET;
			cur_ff.pwr    <= VFDFS_RUN;
		end else if (ce) begin
			cur_ff <= nxt_cur;
		end
	end

	assign spiDout            = cur_ff.dout;
	assign spiDoutEn          = cur_ff.doutEn;
	assign tubeDriverBlank    = cur_ff.blank;
	assign scanOscillatorRun  = cur_ff.pwr != VFDFS_HALTED;
	assign muxPeriodTick      = cur_ff.tick;
	assign pumpOut            = cur_ff.pump;
	assign filamentDriveA     = cur_ff.filA;
	assign filamentDriveB     = cur_ff.filB;
	assign cfgLock            = cur_ff.cfgReg[CFG_LOCK_BIT];
	assign cfgBlinkFast       = cur_ff.cfgReg[CFG_BLINK_BIT];
	assign cfgTwoRow          = cur_ff.cfgReg[CFG_ROWS_BIT];
	assign cfgClearPulse      = cur_ff.clearPulse;
	assign cfgBlinkResetPulse = cur_ff.bresetPulse;

	// ******************************************************************
	// checks
	// ******************************************************************
	chk_halt_blank: assert property (@(posedge mclk) disable iff (sys_rst)
		!scanOscillatorRun |-> tubeDriverBlank)
		else $error("halted without blanking");
	chk_pump_low: assert property (@(posedge mclk) disable iff (sys_rst)
		!scanOscillatorRun |-> !pumpOut)
		else $error("pump active in shutdown");
	chk_fil_low: assert property (@(posedge mclk) disable iff (sys_rst)
		(!scanOscillatorRun && filAIsDriver) |-> !filamentDriveA)
		else $error("filament a active in shutdown");
	chk_halt_edge: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(scanOscillatorRun) |-> $past(cur_ff.muxCnt) == MUX_LAST)
		else $error("halt not at period boundary");
	chk_flush_blank: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(scanOscillatorRun) |-> tubeDriverBlank)
		else $error("no blank after exit");
	chk_ptr_range: assert property (@(posedge mclk) disable iff (sys_rst)
		cur_ff.ptr >= PTR_FIRST && cur_ff.ptr <= PTR_LAST)
		else $error("pointer out of range");
	chk_done_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		cur_ff.ptrDone |-> !ramWr)
		else $error("write after last entry");
	chk_rd_msb: assert property (@(posedge mclk) disable iff (sys_rst)
		$past(cur_ff.rdPending) && $past(ce) |-> !cur_ff.shiftOut[7])
		else $error("read msb set");
endmodule
